// ### tb_tcrl_top.sv
// Self-checking bench for the test control register lock.
// Assumes the design, host model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "tcrl_params.svh"
module tb_tcrl_top;
	import tcrl_pkg::*;
	// Arbitrary password words
	localparam logic [7:0] W1 = 8'hC3;
	localparam logic [7:0] W2 = 8'h3C;
	localparam logic [7:0] TADDR [4] = '{`TCRL_ADDR_PUMP, `TCRL_ADDR_HALT,
		`TCRL_ADDR_BGAP, `TCRL_ADDR_TMODE};
	localparam logic [7:0] TRST [4] = '{`TCRL_RST_PUMP, `TCRL_RST_HALT,
		`TCRL_RST_BGAP, `TCRL_RST_TMODE};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic auto_c = 1'b0;
	logic halt_raw = 1'b0;
	logic [7:0] addr;
	logic wr_en, rd_en, rvalid, pump, hpow, quad, hflag, bgap, unl;
	tcrl_byte_t wdata, rdata, d;
	tcrl_test_mode_t tmode;
	tcrl_byte_t exp_q[$];
	logic [31:0] lfsr = 32'h2224;
	int error_cnt = 0;
	int n_compared = 0;
	int cycles = 0;
	always #50 clk = ~clk;
	tcrl_top #(.UNLOCK_WORD1(W1), .UNLOCK_WORD2(W2)) u_dut (.i_core_clk(clk), .i_rst(rst),
		.i_reg_addr(addr), .i_reg_wr_en(wr_en), .i_reg_wr_data(wdata), .i_reg_rd_en(rd_en),
		.o_reg_rd_valid(rvalid), .o_reg_rd_data(rdata), .i_pump_auto_constant(auto_c),
		.i_clock_halt_raw(halt_raw), .o_pump_constant_current(pump),
		.o_halt_detector_power(hpow), .o_halt_detector_quad_current(quad),
		.o_clock_halt_flag(hflag), .o_bandgap_power(bgap), .o_unlocked(unl),
		.o_test_mode_choice(tmode));
	tcrl_host u_host (.i_core_clk(clk), .o_reg_addr(addr), .o_reg_wr_en(wr_en),
		.o_reg_wr_data(wdata), .o_reg_rd_en(rd_en));
	// ====================================
	// Helpers
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		u_host.xfer(1'b1, a, v);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.xfer(1'b0, a, ~e);
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : idle
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	// ====================================
	// Read monitor and timeout
	// Sampled mid-cycle, where registered outputs have settled
	always @(negedge clk)
	begin
		cycles++;
		if (rvalid === 1'b1)
			chk(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hEE);
		if (cycles == 3000)
		begin
			error_cnt++;
			conclude();
		end
	end
	// ====================================
	// Scenarios
	initial
	begin
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		for (int i = 0; i < 4; i++)
			rd(TADDR[i], 8'h00);
		rd(`TCRL_ADDR_UNLOCK1, 8'h00);
		rd(`TCRL_ADDR_UNLOCK2, 8'h00);
		rd(8'h50, 8'h00);
		wr(`TCRL_ADDR_HALT, 8'h00);
		idle(4);
		chk(8'(hpow), 8'h01);
		u_host.unlock(W1, W2);
		idle(3);
		chk(8'(unl), 8'h01);
		for (int i = 0; i < 4; i++)
			rd(TADDR[i], TRST[i]);
		for (int c = 0; c < 16; c++)
		begin
			lfsr = nxt(lfsr);
			d = {lfsr[7:4], 4'(c)};
			wr(`TCRL_ADDR_TMODE, d);
			rd(`TCRL_ADDR_TMODE, d);
			idle(2);
			chk(8'(tmode), 8'(c < 8 ? c : 0));
		end
		for (int i = 0; i < 4; i++)
		begin
			lfsr = nxt(lfsr);
			auto_c = lfsr[0];
			wr(`TCRL_ADDR_PUMP, {3'h0, 1'(i >> 1), 3'h0, 1'(i)});
			idle(3);
			chk(8'(pump), 8'((i > 1) ? (i & 1) : auto_c));
		end
		wr(`TCRL_ADDR_HALT, 8'h03);
		idle(4);
		chk({5'h00, hpow, quad, hflag}, 8'h03);
		wr(`TCRL_ADDR_HALT, 8'h10);
		idle(4);
		chk({5'h00, hpow, quad, hflag}, 8'h04);
		halt_raw = 1'b1;
		idle(4);
		chk(8'(hflag), 8'h01);
		wr(`TCRL_ADDR_BGAP, 8'h01);
		idle(3);
		chk(8'(bgap), 8'h01);
		wr(`TCRL_ADDR_UNLOCK1, 8'h00);
		idle(3);
		chk({6'h00, unl, bgap}, 8'h00);
		rd(`TCRL_ADDR_BGAP, 8'h00);
		wr(`TCRL_ADDR_BGAP, 8'h00);
		u_host.unlock(W1, W2);
		idle(3);
		rd(`TCRL_ADDR_BGAP, 8'h01);
		idle(4);
		chk(8'(exp_q.size()), 8'h00);
		conclude();
	end
endmodule : tb_tcrl_top
`default_nettype wire

// ### tcrl_host.sv
// Host model making single-byte accesses on the register port.
// Assumes the bench calls its tasks; each strobe lasts one core clock.
`timescale 1ns/1ps
`default_nettype none
`include "tcrl_params.svh"
module tcrl_host (
	input wire logic i_core_clk,
	output var logic [7:0] o_reg_addr,
	output var logic o_reg_wr_en,
	output var logic [7:0] o_reg_wr_data,
	output var logic o_reg_rd_en
);
	initial
	begin
		o_reg_addr = 8'h00;
		o_reg_wr_en = 1'b0;
		o_reg_wr_data = 8'h00;
		o_reg_rd_en = 1'b0;
	end
	// Released lines show inverted values so stale data is never trusted
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		#1;
		o_reg_addr = a;
		o_reg_wr_data = d;
		o_reg_wr_en = w;
		o_reg_rd_en = !w;
		@(posedge i_core_clk);
		#1;
		o_reg_wr_en = 1'b0;
		o_reg_rd_en = 1'b0;
		o_reg_addr = ~a;
		o_reg_wr_data = ~d;
	endtask : xfer
	task automatic unlock(input logic [7:0] w1, input logic [7:0] w2);
		xfer(1'b1, `TCRL_ADDR_UNLOCK1, w1);
		xfer(1'b1, `TCRL_ADDR_UNLOCK2, w2);
	endtask : unlock
endmodule : tcrl_host
`default_nettype wire

// ### tcrl_lock.sv
// Two password words and the unlock decision.
// Assumes writes arrive from the control port decoder on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "tcrl_params.svh"

module tcrl_lock #(
	parameter logic [7:0] WORD1 = `TCRL_UNLOCK1_DEFAULT,
	parameter logic [7:0] WORD2 = `TCRL_UNLOCK2_DEFAULT
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_wr_word1,
	input wire logic i_wr_word2,
	input wire tcrl_pkg::tcrl_byte_t i_wr_data,
	output var tcrl_pkg::tcrl_byte_t o_word1,
	output var tcrl_pkg::tcrl_byte_t o_word2,
	output var logic o_unlocked
);
	import tcrl_pkg::*;

	// =====================================================
	// Password words, always reachable
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_word1 <= `TCRL_RST_UNLOCK;
		end
		else if (i_wr_word1)
		begin
			o_word1 <= i_wr_data;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_word2 <= `TCRL_RST_UNLOCK;
		end
		else if (i_wr_word2)
		begin
			o_word2 <= i_wr_data;
		end
	end

	// =====================================================
	// Unlock state; registered so it trails the second word by one edge
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_unlocked <= 1'b0;
		end
		else
		begin
			o_unlocked <= (o_word1 == WORD1) && (o_word2 == WORD2);
		end
	end

endmodule : tcrl_lock
`default_nettype wire

// ### tcrl_params.svh
// Constants for the test control register lock block.
// Included by the package and by every design file that needs numbers.
`ifndef TCRL_PARAMS_SVH
`define TCRL_PARAMS_SVH

// Register offsets on the serial control port register map
`define TCRL_ADDR_PUMP 8'h2A
`define TCRL_ADDR_HALT 8'h2B
`define TCRL_ADDR_BGAP 8'h2C
`define TCRL_ADDR_UNLOCK1 8'h3F
`define TCRL_ADDR_UNLOCK2 8'h40
`define TCRL_ADDR_TMODE 8'h41

// Reset values
`define TCRL_RST_PUMP 8'h01
`define TCRL_RST_HALT 8'h10
`define TCRL_RST_BGAP 8'h00
`define TCRL_RST_UNLOCK 8'h00
`define TCRL_RST_TMODE 8'h00
`define TCRL_ZERO8 8'h00

// Field positions
`define TCRL_BIT_PUMP_REG_EN 4
`define TCRL_BIT_PUMP_CHOICE 0
`define TCRL_BIT_HALT_POWER 4
`define TCRL_BIT_HALT_QUAD 1
`define TCRL_BIT_HALT_DISABLE 0
`define TCRL_BIT_BGAP_POWER 0
`define TCRL_TMODE_MSB 3
`define TCRL_TMODE_LSB 0

// Default password words; arbitrary values, overridable per instance
`define TCRL_UNLOCK1_DEFAULT 8'hA5
`define TCRL_UNLOCK2_DEFAULT 8'h5A

// Number of lockable test registers
`define TCRL_NUM_TEST 4

// Test mode codes
`define TCRL_TM_NORMAL 4'h0
`define TCRL_TM_SCAN 4'h1
`define TCRL_TM_QUIESCENT 4'h2
`define TCRL_TM_OUT_HIGH 4'h3
`define TCRL_TM_OUT_LOW 4'h4
`define TCRL_TM_IN_LOW 4'h5
`define TCRL_TM_IN_HIGH 4'h6
`define TCRL_TM_HIGH_Z 4'h7

`endif

// ### tcrl_pkg.sv
// Types shared by the test control register lock block.
// Assumes tcrl_params.svh is on the include path.
`include "tcrl_params.svh"

package tcrl_pkg;

	typedef enum logic [3:0] {
		TCRL_TM_NORMAL = `TCRL_TM_NORMAL,
		TCRL_TM_SCAN = `TCRL_TM_SCAN,
		TCRL_TM_QUIESCENT = `TCRL_TM_QUIESCENT,
		TCRL_TM_OUT_HIGH = `TCRL_TM_OUT_HIGH,
		TCRL_TM_OUT_LOW = `TCRL_TM_OUT_LOW,
		TCRL_TM_IN_LOW = `TCRL_TM_IN_LOW,
		TCRL_TM_IN_HIGH = `TCRL_TM_IN_HIGH,
		TCRL_TM_HIGH_Z = `TCRL_TM_HIGH_Z
	} tcrl_test_mode_t;

	typedef logic [7:0] tcrl_byte_t;

endpackage : tcrl_pkg

// ### tcrl_reg8.sv
// One 8-bit lockable register with its own reset value.
// Assumes the caller decodes the address and supplies the lock state.
`timescale 1ns/1ps
`default_nettype none
`include "tcrl_params.svh"

module tcrl_reg8 #(
	parameter logic [7:0] RESET_VALUE = `TCRL_ZERO8
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_sel_wr,
	input wire logic i_unlocked,
	input wire tcrl_pkg::tcrl_byte_t i_wr_data,
	output var tcrl_pkg::tcrl_byte_t o_value
);
	import tcrl_pkg::*;

	// =====================================================
	// Storage; reserved bits kept as written
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_value <= RESET_VALUE;
		end
		else if (i_sel_wr && i_unlocked)
		begin
			o_value <= i_wr_data;
		end
	end

endmodule : tcrl_reg8
`default_nettype wire

// ### tcrl_top.sv
// Test control register bank behind a two-word password lock.
// Assumes the serial control port decoder drives byte accesses on i_core_clk.
//
// Behaviour
// - Pump register-mode enable, bit 4, resets 0; 0 ignores register pump mode.
// - Pump mode choice, bit 0, resets 1; 1 is constant current.
// - Halt detector power, bit 4, resets 1; 1 powers detector up.
// - Halt detector quad current, bit 1, resets 0; 1 quadruples current.
// - Halt detector disable, bit 0, resets 0; 1 forces detector output high.
// - Bandgap power, bit 0, resets 0 (down); applies in test mode (code gates it on the unlock state only, not on the test mode field).
// - Two 8-bit read/write password words, each resetting to zero.
// - Test registers unlock only while both words hold correct values.
// - Writes to locked test registers are discarded, contents kept.
// - Reads of locked test registers return zero.
// - Four-bit test mode field resets to normal; codes 1 to 7 defined.
`timescale 1ns/1ps
`default_nettype none
`include "tcrl_params.svh"

module tcrl_top #(
	parameter logic [7:0] UNLOCK_WORD1 = `TCRL_UNLOCK1_DEFAULT,
	parameter logic [7:0] UNLOCK_WORD2 = `TCRL_UNLOCK2_DEFAULT
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Register access from the control port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr_en,
	input wire tcrl_pkg::tcrl_byte_t i_reg_wr_data,
	input wire logic i_reg_rd_en,
	output logic o_reg_rd_valid,
	output tcrl_pkg::tcrl_byte_t o_reg_rd_data,
	// Pump mode from the automatic controller
	input wire logic i_pump_auto_constant,
	// Raw clock halt detector output, asynchronous
	input wire logic i_clock_halt_raw,
	// Controls toward the analog blocks
	output logic o_pump_constant_current,
	output logic o_halt_detector_power,
	output logic o_halt_detector_quad_current,
	output logic o_clock_halt_flag,
	output logic o_bandgap_power,
	output logic o_unlocked,
	output tcrl_pkg::tcrl_test_mode_t o_test_mode_choice
);
	import tcrl_pkg::*;

	localparam int NT = `TCRL_NUM_TEST;
	localparam int IDX_PUMP = 0;
	localparam int IDX_HALT = 1;
	localparam int IDX_BGAP = 2;
	localparam int IDX_TMODE = 3;

	// =====================================================
	// Address and reset tables for the lockable registers
	function automatic logic [7:0] test_addr(input int idx);
		logic [7:0] a;
		a = `TCRL_ADDR_TMODE;
		case (idx)
			IDX_PUMP: a = `TCRL_ADDR_PUMP;
			IDX_HALT: a = `TCRL_ADDR_HALT;
			IDX_BGAP: a = `TCRL_ADDR_BGAP;
			default: a = `TCRL_ADDR_TMODE;
		endcase
		return a;
	endfunction : test_addr

	function automatic logic [7:0] test_reset(input int idx);
		logic [7:0] r;
		r = `TCRL_RST_TMODE;
		case (idx)
			IDX_PUMP: r = `TCRL_RST_PUMP;
			IDX_HALT: r = `TCRL_RST_HALT;
			IDX_BGAP: r = `TCRL_RST_BGAP;
			default: r = `TCRL_RST_TMODE;
		endcase
		return r;
	endfunction : test_reset

	// =====================================================
	// Password lock
	logic unlocked;
	tcrl_byte_t word1;
	tcrl_byte_t word2;
	logic wr_word1;
	logic wr_word2;

	assign wr_word1 = i_reg_wr_en && (i_reg_addr == `TCRL_ADDR_UNLOCK1);
	assign wr_word2 = i_reg_wr_en && (i_reg_addr == `TCRL_ADDR_UNLOCK2);

	tcrl_lock #(
		.WORD1(UNLOCK_WORD1),
		.WORD2(UNLOCK_WORD2)
	) u_lock (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_wr_word1(wr_word1),
		.i_wr_word2(wr_word2),
		.i_wr_data(i_reg_wr_data),
		.o_word1(word1),
		.o_word2(word2),
		.o_unlocked(unlocked)
	);

	// =====================================================
	// Lockable test registers
	tcrl_byte_t test_val [NT];
	logic [NT-1:0] test_hit;

	genvar gi;
	generate
		for (gi = 0; gi < NT; gi++)
		begin : g_test
			assign test_hit[gi] = (i_reg_addr == test_addr(gi));
			tcrl_reg8 #(
				.RESET_VALUE(test_reset(gi))
			) u_reg (
				.i_core_clk(i_core_clk),
				.i_rst(i_rst),
				.i_sel_wr(i_reg_wr_en && test_hit[gi]),
				.i_unlocked(unlocked),
				.i_wr_data(i_reg_wr_data),
				.o_value(test_val[gi])
			);
		end
	endgenerate

	// =====================================================
	// Read path
	tcrl_byte_t rd_mux;

	always_comb
	begin
		rd_mux = `TCRL_ZERO8;
		if (i_reg_addr == `TCRL_ADDR_UNLOCK1)
		begin
			rd_mux = word1;
		end
		else if (i_reg_addr == `TCRL_ADDR_UNLOCK2)
		begin
			rd_mux = word2;
		end
		else if (unlocked)
		begin
			for (int k = 0; k < NT; k++)
			begin
				if (test_hit[k])
				begin
					rd_mux = test_val[k];
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_reg_rd_data <= `TCRL_ZERO8;
		end
		else if (i_reg_rd_en)
		begin
			o_reg_rd_data <= rd_mux;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_reg_rd_valid <= 1'b0;
		end
		else
		begin
			o_reg_rd_valid <= i_reg_rd_en;
		end
	end

	// =====================================================
	// Charge pump mode
	// Register choice only counts while its enable is set
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_pump_constant_current <= 1'b0;
		end
		else if (test_val[IDX_PUMP][`TCRL_BIT_PUMP_REG_EN])
		begin
			o_pump_constant_current <= test_val[IDX_PUMP][`TCRL_BIT_PUMP_CHOICE];
		end
		else
		begin
			o_pump_constant_current <= i_pump_auto_constant;
		end
	end

	// =====================================================
	// Clock halt detector
	logic halt_meta_q;
	logic halt_sync_q;

	// Detector runs on its own timing, so resynchronise
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			halt_meta_q <= 1'b0;
			halt_sync_q <= 1'b0;
		end
		else
		begin
			halt_meta_q <= i_clock_halt_raw;
			halt_sync_q <= halt_meta_q;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_clock_halt_flag <= 1'b0;
		end
		else if (test_val[IDX_HALT][`TCRL_BIT_HALT_DISABLE])
		begin
			o_clock_halt_flag <= 1'b1;
		end
		else
		begin
			o_clock_halt_flag <= halt_sync_q;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_halt_detector_power <= 1'b1;
			o_halt_detector_quad_current <= 1'b0;
		end
		else
		begin
			o_halt_detector_power <= test_val[IDX_HALT][`TCRL_BIT_HALT_POWER];
			o_halt_detector_quad_current <= test_val[IDX_HALT][`TCRL_BIT_HALT_QUAD];
		end
	end

	// =====================================================
	// Test mode decode
	tcrl_test_mode_t mode_d;

	always_comb
	begin
		case (test_val[IDX_TMODE][`TCRL_TMODE_MSB:`TCRL_TMODE_LSB])
			`TCRL_TM_SCAN: mode_d = TCRL_TM_SCAN;
			`TCRL_TM_QUIESCENT: mode_d = TCRL_TM_QUIESCENT;
			`TCRL_TM_OUT_HIGH: mode_d = TCRL_TM_OUT_HIGH;
			`TCRL_TM_OUT_LOW: mode_d = TCRL_TM_OUT_LOW;
			`TCRL_TM_IN_LOW: mode_d = TCRL_TM_IN_LOW;
			`TCRL_TM_IN_HIGH: mode_d = TCRL_TM_IN_HIGH;
			`TCRL_TM_HIGH_Z: mode_d = TCRL_TM_HIGH_Z;
			default: mode_d = TCRL_TM_NORMAL;
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_test_mode_choice <= TCRL_TM_NORMAL;
		end
		else
		begin
			o_test_mode_choice <= mode_d;
		end
	end

	// =====================================================
	// Bandgap power; only meaningful while test access is open
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_bandgap_power <= 1'b0;
		end
		else
		begin
			o_bandgap_power <= unlocked && test_val[IDX_BGAP][`TCRL_BIT_BGAP_POWER];
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_unlocked <= 1'b0;
		end
		else
		begin
			o_unlocked <= unlocked;
		end
	end

endmodule : tcrl_top
`default_nettype wire

// ### tcrl_top_properties.sv
// Port checker for the test control register lock.
// Assumes one core clock and the asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "tcrl_params.svh"
module tcrl_checker (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr_en,
	input wire logic i_reg_rd_en,
	input wire logic o_reg_rd_valid,
	input wire tcrl_pkg::tcrl_byte_t o_reg_rd_data,
	input wire logic i_pump_auto_constant,
	input wire logic o_pump_constant_current,
	input wire logic o_halt_detector_power,
	input wire logic o_halt_detector_quad_current,
	input wire logic o_bandgap_power,
	input wire logic o_unlocked,
	input wire tcrl_pkg::tcrl_test_mode_t o_test_mode_choice
);
	import tcrl_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	logic test_sel;
	logic pump_wr_q;
	assign test_sel = i_reg_addr inside {`TCRL_ADDR_PUMP, `TCRL_ADDR_HALT,
		`TCRL_ADDR_BGAP, `TCRL_ADDR_TMODE};
	// Any pump write ends the automatic-only phase, even a dropped one
	always_ff @(posedge i_core_clk or posedge i_rst)
		if (i_rst)
			pump_wr_q <= 1'b0;
		else if (i_reg_wr_en && i_reg_addr == `TCRL_ADDR_PUMP)
			pump_wr_q <= 1'b1;
	// ====================================
	// Assertions
	a_rd_valid_pulse: assert property (i_reg_rd_en |=> o_reg_rd_valid)
		else $error("read not answered next cycle");
	a_no_stray_valid: assert property (!i_reg_rd_en |=> !o_reg_rd_valid)
		else $error("read valid without request");
	a_locked_rd_zero: assert property (i_reg_rd_en && test_sel |=>
		(!o_unlocked -> o_reg_rd_data == 8'h00)) else $error("locked read not zero");
	a_unmapped_rd_zero: assert property (i_reg_rd_en && i_reg_addr == 8'h50
		|=> o_reg_rd_data == 8'h00) else $error("unmapped read not zero");
	a_locked_wr_kept: assert property (i_reg_wr_en && i_reg_addr == `TCRL_ADDR_HALT
		##1 !o_unlocked |-> ##1 $stable(o_halt_detector_power) &&
		$stable(o_halt_detector_quad_current)) else $error("locked write took effect");
	a_bgap_needs_unlock: assert property (o_bandgap_power |-> o_unlocked)
		else $error("bandgap powered while locked");
	a_reset_locked: assert property ($past(i_rst) |-> !o_unlocked &&
		o_halt_detector_power && !o_bandgap_power && o_test_mode_choice == TCRL_TM_NORMAL)
		else $error("wrong state after reset");
	a_mode_defined: assert property (o_test_mode_choice <= TCRL_TM_HIGH_Z)
		else $error("undefined test mode driven");
	a_pump_auto: assert property (!pump_wr_q && !$past(i_rst) |->
		o_pump_constant_current == $past(i_pump_auto_constant))
		else $error("pump not following automatic control");
	c_unlock: cover property ($rose(o_unlocked));
	c_read_data: cover property (o_reg_rd_valid && o_reg_rd_data != 8'h00);
	c_locked_wr: cover property (i_reg_wr_en && test_sel && !o_unlocked);
endmodule : tcrl_checker
bind tcrl_top tcrl_checker u_chk (.i_core_clk, .i_rst, .i_reg_addr, .i_reg_wr_en,
	.i_reg_rd_en, .o_reg_rd_valid, .o_reg_rd_data, .i_pump_auto_constant,
	.o_pump_constant_current, .o_halt_detector_power, .o_halt_detector_quad_current,
	.o_bandgap_power, .o_unlocked, .o_test_mode_choice);
`default_nettype wire
